// ### rtl/coproc_branch_pkg.sv
/*
  Constants, types and decode helper for the coprocessor condition branch unit.
  Assumes a single 100 MHz core clock and a synchronous active-high reset.
*/
// Summary of operation
// - Decode fp true branch: opcode 010001, sub 01000, nullify 0, sense 1.
// - Decode fp true-likely branch: same fields, nullify 1, sense 1.
// - Decode second_coproc_opcode false branch: opcode 010010, sub 01000, nullify 0, sense 0.
// - Target is sign-extended offset shifted by 2, added to delay-slot address.
// - Fp true forms branch only when selected code is 1, after delay slot.
// - Likely forms nullify the delay slot when not taken, then go sequential.
// - Second_coproc_opcode false branch taken only when selected second_coproc_opcode condition is 0.
// - Raise coprocessor-unusable, reserved-instruction or fp unimplemented-operation.
// - Fp condition codes change only through the fp compare write.
// - Eight fp condition codes from 0; selector field picks one.
// - Code 0 is the legacy condition: condition signal and bit 0 of the condition register.
package coproc_branch_pkg;

  // ----------------------------------------
  // Instruction encoding
  // ----------------------------------------
  localparam logic [5:0] FPU_MAJOR_OPCODE = 6'h11;
  localparam logic [5:0] SECOND_COPROC_OPCODE = 6'h12;
  localparam logic [4:0] BRANCH_SUBFIELD = 5'h08;
  localparam int OFFSET_SHIFT = 2;
  localparam int NUM_CODES = 8;
  localparam int INSTR_BYTES = 4;

  // ----------------------------------------
  // Register map and reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] COND_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] TARGET_LO_OFS = 8'h0c;
  localparam logic [7:0] TARGET_HI_OFS = 8'h10;
  localparam logic [7:0] TAKEN_CNT_OFS = 8'h14;
  localparam logic [7:0] NULLIFY_CNT_OFS = 8'h18;
  localparam int CTRL_FPU_PRESENT = 0;
  localparam int CTRL_FPU_USABLE = 1;
  localparam int CTRL_SECOND_COPROC_OPCODE_PRESENT = 2;
  localparam int CTRL_SECOND_COPROC_OPCODE_USABLE = 3;
  localparam int CTRL_FP_UNIMPL = 4;
  localparam logic [4:0] CTRL_RESET = 5'h0f;
  localparam logic [7:0] FCC_RESET = 8'h00;
  localparam logic [31:0] CNT_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    BR_NONE = 2'h0,
    BR_FP_TRUE = 2'h1,
    BR_FP_TRUE_LIKELY = 2'h2,
    BR_SECOND_COPROC_OPCODE_FALSE = 2'h3
  } branch_kind_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SLOT = 2'h1,
    ST_REDIRECT = 2'h3
  } seq_state_type;

  typedef struct packed {
    branch_kind_type kind;
    logic [2:0] code_selector;
    logic nullify_flag;
    logic sense_flag;
    logic [15:0] offset;
  } branch_decode_type;

  typedef struct packed {
    logic cop_unusable;
    logic reserved_instr;
    logic fp_unimpl;
  } branch_exc_type;

  function automatic branch_decode_type decode_branch(input logic [31:0] instr);
    branch_decode_type d;
    d.code_selector = instr[20:18];
    d.nullify_flag = instr[17];
    d.sense_flag = instr[16];
    d.offset = instr[15:0];
    d.kind = BR_NONE;
    if (instr[25:21] == BRANCH_SUBFIELD) begin
      if (instr[31:26] == FPU_MAJOR_OPCODE && instr[16]) begin
        d.kind = instr[17] ? BR_FP_TRUE_LIKELY : BR_FP_TRUE;
      end else if (instr[31:26] == SECOND_COPROC_OPCODE && instr[17:16] == 2'b00) begin
        d.kind = BR_SECOND_COPROC_OPCODE_FALSE;
      end
    end
    return d;
  endfunction

endpackage

// ### rtl/cond_code_file.sv
/*
  Eight floating point condition codes with a compare write port.
  Assumes the compare unit runs on the same clock.
*/
`timescale 1ns/1ps
module cond_code_file
  import coproc_branch_pkg::*;
#(
  parameter int N = NUM_CODES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmp_wr_i,
  input wire logic [$clog2(N)-1:0] cmp_idx_i,
  input wire logic cmp_val_i,
  input wire logic [$clog2(N)-1:0] rd_sel_i,
  output logic [N-1:0] codes_o,
  output logic sel_val_o
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      codes_o <= N'(FCC_RESET);
    end else if (cmp_wr_i) begin
      codes_o[cmp_idx_i] <= cmp_val_i;
    end
  end

  assign sel_val_o = codes_o[rd_sel_i];
endmodule

// ### rtl/branch_target_calc.sv
/*
  PC-relative target and fall-through address for a branch.
  Assumes instruction addresses are word aligned.
*/
`timescale 1ns/1ps
module branch_target_calc
  import coproc_branch_pkg::*;
#(
  parameter int GPRLEN = 64
) (
  input wire logic [GPRLEN-1:0] branch_pc_i,
  input wire logic [15:0] offset_i,
  output logic [GPRLEN-1:0] target_o,
  output logic [GPRLEN-1:0] seq_pc_o
);
  logic [GPRLEN-1:0] slot_pc;
  logic [GPRLEN-1:0] ext_ofs;

  function automatic logic [GPRLEN-1:0] step(input logic [GPRLEN-1:0] pc);
    return pc + GPRLEN'(INSTR_BYTES);
  endfunction

  // Offset is relative to the delay slot, not the branch itself
  assign slot_pc = step(branch_pc_i);
  assign ext_ofs = {{(GPRLEN-18){offset_i[15]}}, offset_i, 2'b00};
  assign target_o = slot_pc + ext_ofs;
  assign seq_pc_o = step(slot_pc);
endmodule

// ### rtl/coproc_cond_branch_unit.sv
/*
  Decode and sequencing of coprocessor condition branches with a Wishbone
  classic register slave. Assumes the pipeline presents one instruction at a
  time with its address, reports when the delay slot issues, and honours the
  redirect and nullify outputs.
*/
`timescale 1ns/1ps
module coproc_cond_branch_unit
  import coproc_branch_pkg::*;
#(
  parameter int GPRLEN = 64,
  parameter int N = NUM_CODES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction side
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [GPRLEN-1:0] instr_pc_i,
  output logic ready_o,
  output logic hit_o,
  input wire logic slot_valid_i,
  output logic slot_nullify_o,
  output logic redirect_valid_o,
  output logic redirect_taken_o,
  output logic [GPRLEN-1:0] redirect_pc_o,
  output logic exc_cop_unusable_o,
  output logic exc_reserved_o,
  output logic exc_fp_unimpl_o,
  // Condition sources
  input wire logic cmp_wr_i,
  input wire logic [$clog2(N)-1:0] cmp_idx_i,
  input wire logic cmp_val_i,
  input wire logic [N-1:0] second_coproc_opcode_cond_i,
  output logic fpu_condition_signal_o,
  // Wishbone classic slave
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  seq_state_type state_r;
  seq_state_type state_nxt;
  branch_decode_type dec;
  branch_exc_type exc_nxt;
  branch_exc_type exc_r;
  logic [4:0] ctrl_r;
  logic [N-1:0] fcc;
  logic fcc_sel;
  logic cond_met;
  logic accept;
  logic take_branch;
  logic [GPRLEN-1:0] target;
  logic [GPRLEN-1:0] seq_pc;
  logic [GPRLEN-1:0] target_r;
  logic [GPRLEN-1:0] seq_pc_r;
  logic [GPRLEN-1:0] redirect_pc_r;
  logic [63:0] target_wide;
  logic taken_r;
  logic nullify_r;
  logic redirect_taken_r;
  branch_kind_type last_kind_r;
  logic [31:0] taken_cnt_r;
  logic [31:0] nullify_cnt_r;
  logic wb_req;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic [31:0] rd_mux;
  logic slot_done;
  logic wb_wr;
  logic wb_rd;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Counters wrap silently; software reads them as deltas
  function automatic logic [31:0] bump(input logic [31:0] v);
    return v + 32'h0000_0001;
  endfunction

  // Absent unit wins over unusable, which wins over unimplemented
  function automatic branch_exc_type exc_check(input logic present, input logic usable,
      input logic unimpl);
    branch_exc_type e;
    e = '0;
    if (!present) begin
      e.reserved_instr = 1'b1;
    end else if (!usable) begin
      e.cop_unusable = 1'b1;
    end else if (unimpl) begin
      e.fp_unimpl = 1'b1;
    end
    return e;
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  cond_code_file #(
    .N(N)
  ) u_codes (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmp_wr_i(cmp_wr_i),
    .cmp_idx_i(cmp_idx_i),
    .cmp_val_i(cmp_val_i),
    .rd_sel_i(dec.code_selector),
    .codes_o(fcc),
    .sel_val_o(fcc_sel)
  );

  branch_target_calc #(
    .GPRLEN(GPRLEN)
  ) u_target (
    .branch_pc_i(instr_pc_i),
    .offset_i(dec.offset),
    .target_o(target),
    .seq_pc_o(seq_pc)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign dec = decode_branch(instr_i);
  // Hit shows even while busy; only accept starts a branch
  assign hit_o = instr_valid_i && (dec.kind != BR_NONE);
  assign ready_o = (state_r == ST_IDLE);
  assign accept = hit_o && ready_o;

  // ----------------------------------------
  // Condition select
  // ----------------------------------------
  // No hazard check against a recent compare: software spaces them
  always_comb begin
    unique case (dec.kind)
      BR_FP_TRUE, BR_FP_TRUE_LIKELY: cond_met = (fcc_sel == 1'b1);
      BR_SECOND_COPROC_OPCODE_FALSE: cond_met = (second_coproc_opcode_cond_i[dec.code_selector] == 1'b0);
      BR_NONE: cond_met = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Exception checks
  // ----------------------------------------
  always_comb begin
    exc_nxt = '0;
    if (accept) begin
      if (dec.kind == BR_SECOND_COPROC_OPCODE_FALSE) begin
        // Second_coproc_opcode has no unimplemented-operation case
        exc_nxt = exc_check(ctrl_r[CTRL_SECOND_COPROC_OPCODE_PRESENT], ctrl_r[CTRL_SECOND_COPROC_OPCODE_USABLE],
          1'b0);
      end else begin
        exc_nxt = exc_check(ctrl_r[CTRL_FPU_PRESENT], ctrl_r[CTRL_FPU_USABLE],
          ctrl_r[CTRL_FP_UNIMPL]);
      end
    end
  end

  // Exceptions replace the branch: no slot, no redirect
  assign take_branch = accept && (exc_nxt == '0);

  // ----------------------------------------
  // Exception pulses
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_r <= '0;
    end else begin
      exc_r <= exc_nxt;
    end
  end

  assign exc_cop_unusable_o = exc_r.cop_unusable;
  assign exc_reserved_o = exc_r.reserved_instr;
  assign exc_fp_unimpl_o = exc_r.fp_unimpl;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Delay slot issued while waiting; the redirect follows next cycle
  assign slot_done = (state_r == ST_SLOT) && slot_valid_i;

  // The slot is not checked for being a branch itself; that case is undefined
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take_branch) begin
          state_nxt = ST_SLOT;
        end
      end
      ST_SLOT: begin
        if (slot_valid_i) begin
          state_nxt = ST_REDIRECT;
        end
      end
      ST_REDIRECT: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Captured branch outcome
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taken_r <= 1'b0;
      nullify_r <= 1'b0;
      target_r <= '0;
      seq_pc_r <= '0;
      last_kind_r <= BR_NONE;
    end else if (take_branch) begin
      taken_r <= cond_met;
      nullify_r <= dec.nullify_flag && !cond_met;
      target_r <= target;
      seq_pc_r <= seq_pc;
      last_kind_r <= dec.kind;
    end
  end

  // Slot still executes for non-likely forms
  assign slot_nullify_o = (state_r == ST_SLOT) && nullify_r;

  // ----------------------------------------
  // Redirect after the delay slot
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      redirect_pc_r <= '0;
      redirect_taken_r <= 1'b0;
    end else if (slot_done) begin
      redirect_pc_r <= taken_r ? target_r : seq_pc_r;
      redirect_taken_r <= taken_r;
    end
  end

  assign redirect_valid_o = (state_r == ST_REDIRECT);
  assign redirect_pc_o = redirect_pc_r;
  assign redirect_taken_o = redirect_taken_r;

  // ----------------------------------------
  // Event counters
  // ----------------------------------------
  // Only branches that reach their delay slot are counted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taken_cnt_r <= CNT_RESET;
    end else if (slot_done && taken_r) begin
      taken_cnt_r <= bump(taken_cnt_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nullify_cnt_r <= CNT_RESET;
    end else if (slot_done && nullify_r) begin
      nullify_cnt_r <= bump(nullify_cnt_r);
    end
  end

  // ----------------------------------------
  // Legacy condition
  // ----------------------------------------
  assign fpu_condition_signal_o = fcc[0];

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // One wait state: ack in the cycle after the strobe, then dropped
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_r;
  // Write lands on the acknowledged edge, while the master still holds it
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_r && wb_we_i;
  assign wb_rd = wb_req && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
    end else begin
      wb_ack_r <= wb_req;
    end
  end

  assign wb_ack_o = wb_ack_r;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Control is the only writable register; compare alone sets the codes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (wb_wr && wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[4:0];
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read data is captured with the request so it stands with ack
  assign target_wide = 64'(target_r);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      CTRL_OFS: rd_mux = {27'h0000000, ctrl_r};
      COND_OFS: rd_mux = {{(32-N){1'b0}}, fcc};
      STATUS_OFS: rd_mux = {26'h0000000, nullify_r, taken_r, state_r, last_kind_r};
      TARGET_LO_OFS: rd_mux = target_wide[31:0];
      TARGET_HI_OFS: rd_mux = target_wide[63:32];
      TAKEN_CNT_OFS: rd_mux = taken_cnt_r;
      NULLIFY_CNT_OFS: rd_mux = nullify_cnt_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_r <= 32'h0000_0000;
    end else if (wb_rd) begin
      wb_dat_r <= rd_mux;
    end
  end

  assign wb_dat_o = wb_dat_r;

endmodule

// ### test/coproc_cond_branch_unit_properties.sv
/*
  Port checker for the coprocessor condition branch unit.
  Assumes one clock and a synchronous active-high reset; bound below.
*/
`timescale 1ns/1ps
module coproc_cond_branch_unit_properties
#(
  parameter int N = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic ready_o,
  input wire logic hit_o,
  input wire logic slot_valid_i,
  input wire logic slot_nullify_o,
  input wire logic redirect_valid_o,
  input wire logic exc_cop_unusable_o,
  input wire logic cmp_wr_i,
  input wire logic [$clog2(N)-1:0] cmp_idx_i,
  input wire logic cmp_val_i,
  input wire logic fpu_condition_signal_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_accept;
    hit_o && ready_o;
  endsequence
  sequence s_slot_end;
    !ready_o && slot_valid_i;
  endsequence
  a_hit_decode: assert property (
    hit_o == (instr_valid_i && instr_i[25:21] == 5'h08 &&
    ((instr_i[31:26] == 6'h11 && instr_i[16]) ||
    (instr_i[31:26] == 6'h12 && instr_i[17:16] == 2'h0))))
    else $error("hit flag disagrees with word");
  a_slot_redirect: assert property (s_slot_end |=> redirect_valid_o)
    else $error("no redirect after delay slot");
  a_redirect_once: assert property (redirect_valid_o |=> !redirect_valid_o && ready_o)
    else $error("redirect not a single pulse");
  a_plain_no_nullify: assert property ((s_accept and !instr_i[17]) |=> !slot_nullify_o)
    else $error("plain branch nullified its slot");
  a_nullify_busy: assert property (slot_nullify_o |-> !ready_o)
    else $error("nullify outside a branch");
  a_busy_cause: assert property ($fell(ready_o) |-> $past(hit_o))
    else $error("busy without a decoded branch");
  a_code0_follow: assert property (
    cmp_wr_i && cmp_idx_i == 0 |=> fpu_condition_signal_o == $past(cmp_val_i))
    else $error("legacy condition missed a compare");
  a_code0_hold: assert property (
    !(cmp_wr_i && cmp_idx_i == 0) |=> $stable(fpu_condition_signal_o))
    else $error("legacy condition changed by itself");
  a_exc_idle: assert property (exc_cop_unusable_o |-> ready_o)
    else $error("unusable exception started a branch");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than a cycle");
endmodule

bind coproc_cond_branch_unit coproc_cond_branch_unit_properties #(.N(N)) i_props (
  .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .ready_o(ready_o), .hit_o(hit_o), .slot_valid_i(slot_valid_i),
  .slot_nullify_o(slot_nullify_o), .redirect_valid_o(redirect_valid_o),
  .exc_cop_unusable_o(exc_cop_unusable_o), .cmp_wr_i(cmp_wr_i), .cmp_idx_i(cmp_idx_i),
  .cmp_val_i(cmp_val_i), .fpu_condition_signal_o(fpu_condition_signal_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// ### test/cond_source_model.sv
/*
  Model of the compare unit and the second coprocessor condition outputs.
  Assumes the caller sits on the same clock edge discipline.
*/
`timescale 1ns/1ps
module cond_source_model
#(
  parameter int N = 8
) (
  input wire logic clk_i,
  output logic cmp_wr_o,
  output logic [$clog2(N)-1:0] cmp_idx_o,
  output logic cmp_val_o,
  output logic [N-1:0] second_coproc_opcode_cond_o
);
  initial begin
    cmp_wr_o = 1'b0;
    cmp_idx_o = '0;
    cmp_val_o = 1'b0;
    second_coproc_opcode_cond_o = '0;
  end
  // ----------------------------------------
  // Compare writes, one code each
  // ----------------------------------------
  task automatic compare(input logic [$clog2(N)-1:0] idx, input logic val);
    @(posedge clk_i);
    cmp_wr_o <= 1'b1;
    cmp_idx_o <= idx;
    cmp_val_o <= val;
    @(posedge clk_i);
    cmp_wr_o <= 1'b0;
    // Released lines flip, so a stale value cannot pass
    cmp_idx_o <= ~idx;
    cmp_val_o <= ~val;
  endtask
  // Per-code levels held until changed
  task automatic second_coproc_opcode_levels(input logic [N-1:0] v);
    @(posedge clk_i);
    second_coproc_opcode_cond_o <= v;
  endtask
endmodule

// ### test/tb.sv
/*
  Self-checking bench for the coprocessor condition branch unit.
  Assumes the condition source model and the bound checker.
*/
`timescale 1ns/1ps
module tb
  import coproc_branch_pkg::*;
;
  typedef struct packed {
    logic [31:0] ins;
    logic cnd;
    logic hit;
    logic tkn;
    logic nul;
  } row_type;
  typedef struct packed {
    logic [4:0] ctl;
    logic [31:0] ins;
    branch_exc_type exc;
  } exc_row_type;
  // ----------------------------------------
  // Cases
  // ----------------------------------------
  row_type rows [8] = '{'{32'h450d0010, 1, 1, 1, 0}, '{32'h451dfffc, 0, 1, 0, 0},
    '{32'h45030020, 1, 1, 1, 0}, '{32'h45178000, 0, 1, 0, 1}, '{32'h49087fff, 0, 1, 1, 0},
    '{32'h49180004, 1, 1, 0, 0}, '{32'h45000004, 0, 0, 0, 0}, '{32'h49030004, 0, 0, 0, 0}};
  exc_row_type exc_rows [5] = '{'{5'h0d, 32'h45010004, 3'h4}, '{5'h0c, 32'h45010004, 3'h2},
    '{5'h1f, 32'h45010004, 3'h1}, '{5'h07, 32'h49000004, 3'h4}, '{5'h03, 32'h49000004, 3'h2}};
  logic clk_i, rst_i, instr_valid_i, slot_valid_i, ready_o, hit_o, slot_nullify_o;
  logic redirect_valid_o, redirect_taken_o, exc_cop_unusable_o, exc_reserved_o;
  logic exc_fp_unimpl_o, cmp_wr_i, cmp_val_i, fpu_condition_signal_o;
  logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [2:0] cmp_idx_i;
  logic [7:0] second_coproc_opcode_cond_i, wb_adr_i;
  logic [31:0] instr_i, wb_dat_i, wb_dat_o;
  logic [63:0] instr_pc_i, redirect_pc_o;
  logic [3:0] wb_sel_i = 4'hf;
  int error_cnt = 0;
  int check_count = 0;
  coproc_cond_branch_unit i_coproc_cond_branch_unit (.*);
  cond_source_model i_cond_source_model (.clk_i(clk_i), .cmp_wr_o(cmp_wr_i),
    .cmp_idx_o(cmp_idx_i), .cmp_val_o(cmp_val_i), .second_coproc_opcode_cond_o(second_coproc_opcode_cond_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int k);
    if (k >= 20) begin
      error_cnt++;
      end_sim();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd);
    int k;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
    bound(k);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic issue(input logic [31:0] ins, input logic [63:0] pc, input logic go,
      output logic h, n, r, output branch_exc_type e, output logic t, output logic [63:0] rp);
    int k;
    t = 1'b0;
    rp = '0;
    @(posedge clk_i);
    {instr_valid_i, instr_i, instr_pc_i} <= {1'b1, ins, pc};
    #1 h = hit_o;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1 {n, r, e} = {slot_nullify_o, ready_o, exc_cop_unusable_o, exc_reserved_o,
      exc_fp_unimpl_o};
    if (go) begin
      @(posedge clk_i);
      slot_valid_i <= 1'b1;
      @(posedge clk_i);
      slot_valid_i <= 1'b0;
      for (k = 0; k < 20 && redirect_valid_o !== 1'b1; k++) @(posedge clk_i);
      bound(k);
      {t, rp} = {redirect_taken_o, redirect_pc_o};
    end
  endtask
  // ----------------------------------------
  // Clock and sequence
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    logic h, n, r, t;
    logic [63:0] pc, rp;
    logic [31:0] rd;
    logic [7:0] fcc, m;
    logic [2:0] cc;
    int tk, nl;
    branch_exc_type e;
    fcc = 8'h00;
    tk = 0;
    nl = 0;
    {rst_i, instr_valid_i, slot_valid_i, wb_we_i, wb_cyc_i, wb_stb_i} = 6'h20;
    {instr_i, instr_pc_i, wb_adr_i, wb_dat_i} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      pc = 64'h1000 + 64'(i * 16);
      cc = rows[i].ins[20:18];
      if (rows[i].ins[31:26] == SECOND_COPROC_OPCODE) begin
        // Neighbours opposite, so a wrong selector shows
        m = {8{~rows[i].cnd}};
        m[cc] = rows[i].cnd;
        i_cond_source_model.second_coproc_opcode_levels(m);
      end else begin
        i_cond_source_model.compare(cc ^ 3'h1, ~rows[i].cnd);
        i_cond_source_model.compare(cc, rows[i].cnd);
        fcc[cc ^ 3'h1] = ~rows[i].cnd;
        fcc[cc] = rows[i].cnd;
      end
      issue(rows[i].ins, pc, rows[i].hit, h, n, r, e, t, rp);
      tk += int'(rows[i].tkn);
      nl += int'(rows[i].nul);
      check(h, rows[i].hit);
      check(n, rows[i].nul);
      if (rows[i].hit) begin
        check(t, rows[i].tkn);
        check(rp, rows[i].tkn ? pc + 4 + {{46{rows[i].ins[15]}}, rows[i].ins[15:0], 2'h0}
          : pc + 8);
      end
      $display("case %0d done", i);
    end
    wb(1'b0, COND_OFS, 32'h0, rd);
    check(rd, fcc);
    check(fpu_condition_signal_o, fcc[0]);
    wb(1'b1, COND_OFS, 32'hff, rd);
    wb(1'b0, COND_OFS, 32'h0, rd);
    check(rd, fcc);
    wb(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    wb(1'b0, TAKEN_CNT_OFS, 32'h0, rd);
    check(rd, 32'(tk));
    wb(1'b0, NULLIFY_CNT_OFS, 32'h0, rd);
    check(rd, 32'(nl));
    wb(1'b0, TARGET_LO_OFS, 32'h0, rd);
    check(rd, 32'h0000_1064);
    $display("register test done");
    foreach (exc_rows[i]) begin
      wb(1'b1, CTRL_OFS, 32'(exc_rows[i].ctl), rd);
      issue(exc_rows[i].ins, 64'h2000, 1'b0, h, n, r, e, t, rp);
      check(e, exc_rows[i].exc);
      check(r, 1'b1);
    end
    $display("exception test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 check({ready_o, fpu_condition_signal_o}, 2'h2);
    wb(1'b0, CTRL_OFS, 32'h0, rd);
    check(rd, 32'(CTRL_RESET));
    wb(1'b0, COND_OFS, 32'h0, rd);
    check(rd, 32'(FCC_RESET));
    wb(1'b0, TAKEN_CNT_OFS, 32'h0, rd);
    check(rd, 32'(CNT_RESET));
    $display("reset test done");
    end_sim();
  end
endmodule
